// *** rtl/tws_regs.svh ***
// Purpose: timing counts and bus codes for the two-wire slave link
// Assumes: 250 MHz device clock
// Notes:   definitions only
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
// =========================================================
// timing
`define TWS_CLK_MHZ          250
`define TWS_SETTLE_US        10000
`define TWS_SETTLE_CYCLES    (`TWS_SETTLE_US * `TWS_CLK_MHZ)
`define TWS_STALL_CYCLES     50000
`define TWS_QTR_CYCLES       16'h003F
// =========================================================
// framing and address byte
`define TWS_LAST_BIT         4'h8
`define TWS_LAST_SLOT        4'h8
`define TWS_TYPE_MEM         4'hA
`define TWS_TYPE_PROT        4'h6
`define TWS_PAGE_SEL_RESET   1'h0
`endif

// *** rtl/tws_pkg.sv ***
// Purpose: shared types of the two-wire slave link
// Assumes: constants live in tws_regs.svh
// Notes:   binary state codes written out
package tws_pkg;
  // =======================================================
  // device states
  typedef enum logic [2:0] {
    D_IDLE    = 3'b000,
    D_ADDR    = 3'b001,
    D_ADDR_AK = 3'b010,
    D_WR      = 3'b011,
    D_WR_AK   = 3'b100,
    D_RD      = 3'b101,
    D_RD_AK   = 3'b110
  } tws_dev_state_e;
  // host states and commands
  typedef enum logic [2:0] {
    H_SETTLE = 3'b000,
    H_IDLE   = 3'b001,
    H_START  = 3'b010,
    H_BIT    = 3'b011,
    H_STOP   = 3'b100
  } tws_host_state_e;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } tws_op_e;
endpackage : tws_pkg

// *** rtl/tws_if.sv ***
// Purpose: the two open-drain wires between master and slave
// Assumes: pull-ups on both lines
// Notes:   a line is low while any enabled driver drives 0
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl_line;
  logic sda_line;
  // =======================================================
  // wired-and resolution with pull-up
  assign scl_line = ~(host_scl_oe & ~host_scl_o);
  assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (input scl_line, sda_line,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
  modport device (input scl_line, sda_line, output dev_sda_o, dev_sda_oe);
endinterface : tws_if
`default_nettype wire

// *** rtl/tws_line_sync.sv ***
// Purpose: two-flop synchroniser and edge finder for both wires
// Assumes: lines are asynchronous to clk_i
// Notes:   edges come in the same cycle as the synchronised level
`timescale 1ns/1ps
`default_nettype none
module tws_line_sync (
  input  wire logic clk_i,      // device clock
  input  wire logic reset_i,    // sync reset
  input  wire logic scl_i,      // raw clock line
  input  wire logic sda_i,      // raw data line
  output var  logic scl_o,      // synced clock level
  output var  logic sda_o,      // synced data level
  output var  logic scl_rise_o, // clock rose
  output var  logic scl_fall_o, // clock fell
  output var  logic sda_rise_o, // data rose
  output var  logic sda_fall_o  // data fell
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  // =======================================================
  // first flop feeds only the second; idle lines read high
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_o    <= 1'h1;
      sda_o    <= 1'h1;
    end else begin
      scl_meta <= {scl_meta[0], scl_i};
      sda_meta <= {sda_meta[0], sda_i};
      scl_o    <= scl_meta[1];
      sda_o    <= sda_meta[1];
    end
  end
  // edges compare second flop with the held level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_rise_o <= 1'h0;
      scl_fall_o <= 1'h0;
      sda_rise_o <= 1'h0;
      sda_fall_o <= 1'h0;
    end else begin
      scl_rise_o <= scl_meta[1] & ~scl_o;
      scl_fall_o <= ~scl_meta[1] & scl_o;
      sda_rise_o <= sda_meta[1] & ~sda_o;
      sda_fall_o <= ~sda_meta[1] & sda_o;
    end
  end
endmodule : tws_line_sync
`default_nettype wire

// *** rtl/tws_device.sv ***
// Purpose: slave end of the two-wire link
// Assumes: master owns the clock; user logic answers on clk_i
// Notes:   SCL and SDA are oversampled, no clock stretching
// Contract
// R1: sample on SCL rise, drive after fall
// R2: bytes travel most significant bit first
// R3: eight data clocks plus ninth acknowledge clock
// R4: master clocks bytes without idle gaps
// R5: SDA change while SCL high is start/stop
// R6: any number of bytes per transfer
// R7: bus idle only with both lines high
// R8: start is SDA falling with SCL high
// R9: ignore everything until a start
// R10: stop ends transfer, back to idle
// R11: repeated start restarts without idle
// R12: hold SDA low through acknowledge clock
// R13: master releases SDA for slave acknowledge
// R14: master NACK ends read, slave releases
// R15: user may refuse a byte with NACK
// R16: standby at power-up and after stop
// R17: reset defaults, page select cleared
// R18: master waits settle time before command
// R19: long SCL low resets interface
// R20: master keeps SCL at least 10 kHz
// R21: start, nine clocks, start, stop recovers
// R22: address byte type and straps must match
// R23: eighth address bit high selects read
// R24: timeout and settle are cycle parameters
`timescale 1ns/1ps
`include "tws_regs.svh"
`default_nettype none
module tws_device #(
  parameter int unsigned STALL_CYCLES  = `TWS_STALL_CYCLES,  // bus_stall_timeout
  parameter int unsigned SETTLE_CYCLES = `TWS_SETTLE_CYCLES  // power_on_settle_time
) (
  input  wire logic       clk_i,                // device clock
  input  wire logic       reset_i,              // sync reset
  tws_if.device           bus,                  // link wires
  input  wire logic [2:0] address_strap_pins_i, // strap pins
  input  wire logic       reject_i,             // refuse current write byte
  input  wire logic [7:0] tx_data_i,            // next byte to send
  input  wire logic       ops_busy_i,           // internal work pending
  input  wire logic       page_wr_i,            // load page select
  input  wire logic       page_i,               // page select value
  output var  logic       ready_o,              // settle time over
  output var  logic       standby_o,            // low-power standby
  output var  logic       sel_valid_o,          // address byte matched
  output var  logic [3:0] sel_type_o,           // received type code
  output var  logic       sel_read_o,           // transfer is a read
  output var  logic       rx_valid_o,           // written byte pulse
  output var  logic [7:0] rx_data_o,            // written byte
  output var  logic       tx_taken_o,           // tx_data_i consumed
  output var  logic       stop_o,               // transfer ended
  output var  logic       eeprom_page_select_o  // page select
);
  tws_pkg::tws_dev_state_e state;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_rise;
  logic       sda_fall;
  logic [2:0] strap_meta;
  logic [2:0] strap;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic       drive_low;
  logic       read_acked;
  logic       matched;
  logic       start_seen;
  logic       stop_seen;
  logic       stall;
  logic       load_rd;
  logic [7:0] next_rx;
  logic [31:0] low_cnt;
  logic [31:0] settle_cnt;

  // =======================================================
  // line sampling
  tws_line_sync u_sync (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .scl_i      (bus.scl_line),
    .sda_i      (bus.sda_line),
    .scl_o      (scl_s),
    .sda_o      (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .sda_rise_o (sda_rise),
    .sda_fall_o (sda_fall)
  );

  // open-drain output: only ever pulls low
  assign bus.dev_sda_o  = 1'h0;
  assign bus.dev_sda_oe = drive_low;

  // address byte decode: type code and strap bits must both match
  function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] s);
    return ((b[7:4] == `TWS_TYPE_MEM) | (b[7:4] == `TWS_TYPE_PROT)) & (b[3:1] == s);
  endfunction : addr_hit

  // straps are pins: two flops before use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_meta <= 3'h0;
      strap      <= 3'h0;
    end else begin
      strap_meta <= address_strap_pins_i;
      strap      <= strap_meta;
    end
  end

  // =======================================================
  // conditions seen on the wires
  assign start_seen = ready_o & sda_fall & scl_s;            // R5 R8 R9
  assign stop_seen  = sda_rise & scl_s;                      // R5 R10
  assign stall      = ~scl_s & (low_cnt >= STALL_CYCLES - 1); // R19 R24
  assign next_rx    = {rx_shift[6:0], sda_s};                // R2
  assign matched    = addr_hit(rx_shift, strap);             // R22
  assign load_rd    = scl_fall &
                      (((state == tws_pkg::D_ADDR_AK) & sel_read_o) |
                       ((state == tws_pkg::D_RD_AK) & read_acked));

  // scl low-time counter for the stall timeout
  always_ff @(posedge clk_i) begin
    if (reset_i || scl_s) begin
      low_cnt <= 32'h0;
    end else if (low_cnt < STALL_CYCLES) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  // settle counter after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      settle_cnt <= 32'h0;
      ready_o    <= 1'h0;
    end else if (settle_cnt >= SETTLE_CYCLES - 1) begin
      ready_o    <= 1'h1;                                    // R24
    end else begin
      settle_cnt <= settle_cnt + 32'h1;
    end
  end

  // =======================================================
  // byte engine
  always_ff @(posedge clk_i) begin
    rx_valid_o  <= 1'h0;
    sel_valid_o <= 1'h0;
    tx_taken_o  <= 1'h0;
    stop_o      <= 1'h0;
    if (reset_i) begin
      state      <= tws_pkg::D_IDLE;
      bit_cnt    <= 4'h0;
      rx_shift   <= 8'h0;
      tx_shift   <= 8'h0;
      drive_low  <= 1'h0;
      read_acked <= 1'h0;
      rx_data_o  <= 8'h0;
      sel_type_o <= 4'h0;
      sel_read_o <= 1'h0;
    end else if (stall) begin
      state     <= tws_pkg::D_IDLE;                          // R19
      drive_low <= 1'h0;
    end else if (start_seen) begin
      state     <= tws_pkg::D_ADDR;                          // R11 R21
      bit_cnt   <= 4'h0;
      drive_low <= 1'h0;
    end else if (stop_seen) begin
      stop_o    <= (state != tws_pkg::D_IDLE);
      state     <= tws_pkg::D_IDLE;                          // R7 R10
      drive_low <= 1'h0;
    end else if (load_rd) begin
      state      <= tws_pkg::D_RD;
      bit_cnt    <= 4'h0;
      drive_low  <= ~tx_data_i[7];                           // R1 R2
      tx_shift   <= {tx_data_i[6:0], 1'h1};
      tx_taken_o <= 1'h1;
    end else begin
      case (state)
        tws_pkg::D_ADDR, tws_pkg::D_WR: begin
          if (scl_rise && bit_cnt != `TWS_LAST_BIT) begin
            rx_shift <= next_rx;                             // R1
            bit_cnt  <= bit_cnt + 4'h1;
            if (bit_cnt == `TWS_LAST_BIT - 4'h1) begin
              if (state == tws_pkg::D_ADDR) begin
                sel_valid_o <= addr_hit(next_rx, strap);
                sel_type_o  <= next_rx[7:4];
                sel_read_o  <= next_rx[0];                   // R23
              end else begin
                rx_valid_o <= 1'h1;
                rx_data_o  <= next_rx;
              end
            end
          end else if (scl_fall && bit_cnt == `TWS_LAST_BIT) begin
            bit_cnt <= 4'h0;
            if (state == tws_pkg::D_ADDR) begin
              drive_low <= matched;                          // R12 R22
              state     <= matched ? tws_pkg::D_ADDR_AK : tws_pkg::D_IDLE;
            end else begin
              drive_low <= ~reject_i;                        // R12 R15
              state     <= tws_pkg::D_WR_AK;
            end
          end
        end
        tws_pkg::D_ADDR_AK, tws_pkg::D_WR_AK: begin
          if (scl_fall) begin
            drive_low <= 1'h0;                               // R3 R6
            state     <= tws_pkg::D_WR;
          end
        end
        tws_pkg::D_RD: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == `TWS_LAST_BIT) begin
              drive_low <= 1'h0;                             // R3
              bit_cnt   <= 4'h0;
              state     <= tws_pkg::D_RD_AK;
            end else begin
              drive_low <= ~tx_shift[7];                     // R1 R2
              tx_shift  <= {tx_shift[6:0], 1'h1};
            end
          end
        end
        tws_pkg::D_RD_AK: begin
          if (scl_rise) begin
            read_acked <= ~sda_s;
          end else if (scl_fall) begin
            state <= tws_pkg::D_IDLE;                        // R14
          end
        end
        default: begin
          state     <= tws_pkg::D_IDLE;                      // R9
          drive_low <= 1'h0;
        end
      endcase
    end
  end

  // =======================================================
  // standby and page select
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      standby_o <= 1'h1;                                     // R16
    end else begin
      standby_o <= (state == tws_pkg::D_IDLE) & ~ops_busy_i; // R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      eeprom_page_select_o <= `TWS_PAGE_SEL_RESET;           // R17
    end else if (page_wr_i) begin
      eeprom_page_select_o <= page_i;
    end
  end
endmodule : tws_device
`default_nettype wire

// *** rtl/tws_host.sv ***
// Purpose: master end of the two-wire link
// Assumes: one command at a time from user logic
// Notes:   SCL period is four quarter ticks of the divider
`timescale 1ns/1ps
`include "tws_regs.svh"
`default_nettype none
module tws_host #(
  parameter int unsigned SETTLE_CYCLES = `TWS_SETTLE_CYCLES  // power_on_settle_time
) (
  input  wire logic             clk_i,       // device clock
  input  wire logic             reset_i,     // sync reset
  tws_if.host                   bus,         // link wires
  input  wire logic             cmd_valid_i, // command offered
  input  wire tws_pkg::tws_op_e cmd_op_i,    // start, write, read, stop
  input  wire logic [7:0]       cmd_data_i,  // byte to write
  input  wire logic             cmd_ack_i,   // acknowledge a read byte
  output var  logic             cmd_ready_o, // command taken when high
  output var  logic             rsp_valid_o, // byte slot done pulse
  output var  logic [7:0]       rsp_data_o,  // byte read back
  output var  logic             rsp_nack_o   // ninth bit was high
);
  tws_pkg::tws_host_state_e state;
  logic        sda_s;
  logic [15:0] qcnt;
  logic        tick;
  logic [1:0]  ph;
  logic [3:0]  slot;
  logic [8:0]  tx9;
  logic [8:0]  rx9;
  logic        scl_low;
  logic        sda_low;
  logic [31:0] settle_cnt;

  // =======================================================
  // data line readback
  tws_line_sync u_sync (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .scl_i      (bus.scl_line),
    .sda_i      (bus.sda_line),
    .scl_o      (),
    .sda_o      (sda_s),
    .scl_rise_o (),
    .scl_fall_o (),
    .sda_rise_o (),
    .sda_fall_o ()
  );

  assign bus.host_scl_o  = 1'h0;
  assign bus.host_scl_oe = scl_low;
  assign bus.host_sda_o  = 1'h0;
  assign bus.host_sda_oe = sda_low;

  // quarter-period enable
  always_ff @(posedge clk_i) begin
    if (reset_i || state == tws_pkg::H_IDLE || tick) begin
      qcnt <= 16'h0;
    end else begin
      qcnt <= qcnt + 16'h1;
    end
  end
  assign tick = (qcnt == `TWS_QTR_CYCLES - 16'h1); // R20

  // =======================================================
  // command sequencer
  always_ff @(posedge clk_i) begin
    rsp_valid_o <= 1'h0;
    if (reset_i) begin
      state       <= tws_pkg::H_SETTLE;
      settle_cnt  <= 32'h0;
      ph          <= 2'h0;
      slot        <= 4'h0;
      tx9         <= 9'h1FF;
      rx9         <= 9'h0;
      scl_low     <= 1'h0;
      sda_low     <= 1'h0;
      cmd_ready_o <= 1'h0;
      rsp_data_o  <= 8'h0;
      rsp_nack_o  <= 1'h0;
    end else begin
      case (state)
        tws_pkg::H_SETTLE: begin
          settle_cnt <= settle_cnt + 32'h1;
          if (settle_cnt >= SETTLE_CYCLES - 1) begin
            state       <= tws_pkg::H_IDLE;                  // R18
            cmd_ready_o <= 1'h1;
          end
        end
        tws_pkg::H_IDLE: begin
          ph   <= 2'h0;
          slot <= 4'h0;
          if (cmd_valid_i) begin
            cmd_ready_o <= 1'h0;
            case (cmd_op_i)
              tws_pkg::OP_START: state <= tws_pkg::H_START;
              tws_pkg::OP_STOP:  state <= tws_pkg::H_STOP;
              tws_pkg::OP_WRITE: begin
                state <= tws_pkg::H_BIT;
                tx9   <= {cmd_data_i, 1'h1};                 // R2 R13
              end
              default: begin
                state <= tws_pkg::H_BIT;
                tx9   <= {8'hFF, ~cmd_ack_i};                // R14
              end
            endcase
          end
        end
        tws_pkg::H_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_low <= 1'h0;
              2'h1: scl_low <= 1'h0;
              2'h2: sda_low <= 1'h1;                         // R5 R8
              default: begin
                scl_low     <= 1'h1;
                state       <= tws_pkg::H_IDLE;
                cmd_ready_o <= 1'h1;
              end
            endcase
          end
        end
        tws_pkg::H_STOP: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_low <= 1'h1;
              2'h1: scl_low <= 1'h0;
              2'h2: sda_low <= 1'h0;                         // R5 R7 R10
              default: begin
                state       <= tws_pkg::H_IDLE;
                cmd_ready_o <= 1'h1;
              end
            endcase
          end
        end
        tws_pkg::H_BIT: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_low <= ~tx9[8];                      // R5
              2'h1: scl_low <= 1'h0;
              2'h2: rx9 <= {rx9[7:0], sda_s};
              default: begin
                scl_low <= 1'h1;
                tx9     <= {tx9[7:0], 1'h1};
                slot    <= slot + 4'h1;
                if (slot == `TWS_LAST_SLOT) begin
                  state       <= tws_pkg::H_IDLE;            // R3 R4
                  sda_low     <= 1'h0;
                  cmd_ready_o <= 1'h1;
                  rsp_valid_o <= 1'h1;
                  rsp_data_o  <= rx9[8:1];
                  rsp_nack_o  <= rx9[0];
                end
              end
            endcase
          end
        end
        default: state <= tws_pkg::H_IDLE;
      endcase
    end
  end
endmodule : tws_host
`default_nettype wire

// *** test/tws_properties.sv ***
// Purpose: wire-level checks of the two-wire link
// Assumes: one clock domain, clk_i samples the wires
// Notes:   STALL is the shortened bus_stall_timeout
`timescale 1ns/1ps
`default_nettype none
module tws_properties #(
  parameter int unsigned STALL = 2000  // bus_stall_timeout in clk
) (
  input wire logic clk_i,       // device clock
  input wire logic reset_i,     // sync reset
  input wire logic scl_line,    // resolved clock line
  input wire logic sda_line,    // resolved data line
  input wire logic host_sda_oe, // master pulls data low
  input wire logic dev_sda_oe   // slave pulls data low
);
  logic [15:0] low_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // =======================================================
  // clock-low length, saturating
  always_ff @(posedge clk_i) begin
    if (reset_i || scl_line) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  end
  // bus conditions
  sequence start_s; scl_line && $fell(sda_line); endsequence
  sequence stop_s; scl_line && $rose(sda_line); endsequence
  // =======================================================
  // properties
  AST_DRIVE_ON_LOW: assert property ($changed(dev_sda_oe) |-> !scl_line)
    else $error("slave data changed with clock high");
  AST_ACK_HOLD: assert property ($rose(dev_sda_oe) |-> (dev_sda_oe && !scl_line) [*8])
    else $error("slave pull not held in low phase");
  AST_HIGH_STABLE: assert property ($rose(scl_line) && dev_sda_oe |-> dev_sda_oe [*8])
    else $error("slave pull dropped in high phase");
  AST_NO_FIGHT: assert property (dev_sda_oe && scl_line |-> !host_sda_oe)
    else $error("both ends drive data in high phase");
  AST_STOP_FREE: assert property (stop_s |-> !dev_sda_oe [*8])
    else $error("slave drives after stop");
  AST_START_FREE: assert property (start_s |-> !dev_sda_oe)
    else $error("slave drives at start");
  AST_STALL_RELEASE: assert property (low_cnt == 16'(STALL + 16) |-> !dev_sda_oe)
    else $error("slave holds data after stall");
  AST_SCL_HIGH: assert property ($rose(scl_line) |-> scl_line [*8])
    else $error("clock high phase too short");
  COV_START: cover property (start_s);
endmodule : tws_properties
`default_nettype wire

// *** test/two_wire_slave_interface_tb.sv ***
// Purpose: both link ends face each other, user sides driven here
// Assumes: shortened settle and stall counts
// Notes:   expectations come from bench functions
`timescale 1ns/1ps
`include "tws_regs.svh"
`default_nettype none
module two_wire_slave_interface_tb;
  localparam int unsigned STALL  = 2000; // shortened bus_stall_timeout
  localparam int unsigned SETTLE = 50;   // shortened power_on_settle_time
  logic clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0, cmd_ack_i = 1'b1;
  tws_pkg::tws_op_e cmd_op_i = tws_pkg::OP_START;
  logic [7:0] cmd_data_i = 8'h00, tx_data_i = 8'h00, rsp_data_o, rx_data_o, rx_last;
  logic [2:0] strap = 3'h5;
  logic reject_i = 1'b0, ops_busy_i = 1'b0, page_wr_i = 1'b0, page_i = 1'b0;
  logic cmd_ready_o, rsp_valid_o, rsp_nack_o, ready_o, standby_o, sel_valid_o;
  logic sel_read_o, rx_valid_o, tx_taken_o, stop_o, page_o, scl_q;
  logic [3:0] sel_type_o;
  int n_fail = 0, n_tests = 0, rise_cnt = 0, stop_cnt = 0, seed = 32'hED07;
  int sel_cnt = 0, take_cnt = 0;
  tws_if tws_if_i ();
  tws_device #(.STALL_CYCLES(STALL), .SETTLE_CYCLES(SETTLE)) tws_device_i (
    .clk_i(clk_i), .reset_i(reset_i), .bus(tws_if_i), .address_strap_pins_i(strap),
    .reject_i(reject_i), .tx_data_i(tx_data_i), .ops_busy_i(ops_busy_i),
    .page_wr_i(page_wr_i), .page_i(page_i), .ready_o(ready_o), .standby_o(standby_o),
    .sel_valid_o(sel_valid_o), .sel_type_o(sel_type_o), .sel_read_o(sel_read_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .tx_taken_o(tx_taken_o),
    .stop_o(stop_o), .eeprom_page_select_o(page_o));
  tws_host #(.SETTLE_CYCLES(SETTLE)) tws_host_i (
    .clk_i(clk_i), .reset_i(reset_i), .bus(tws_if_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_nack_o(rsp_nack_o));
  tws_properties #(.STALL(STALL)) tws_properties_i (
    .clk_i(clk_i), .reset_i(reset_i), .scl_line(tws_if_i.scl_line),
    .sda_line(tws_if_i.sda_line), .host_sda_oe(tws_if_i.host_sda_oe),
    .dev_sda_oe(tws_if_i.dev_sda_oe));
  // =======================================================
  // clock and watchdog
  always #2 clk_i = ~clk_i;
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
  // monitor: last written byte, clock rises, stops
  always @(posedge clk_i) begin
    scl_q <= tws_if_i.scl_line;
    if (tws_if_i.scl_line && !scl_q) rise_cnt <= rise_cnt + 1;
    if (rx_valid_o) rx_last <= rx_data_o;
    if (stop_o) stop_cnt <= stop_cnt + 1;
    if (sel_valid_o) sel_cnt <= sel_cnt + 1;
    if (tx_taken_o) take_cnt <= take_cnt + 1;
  end
  // =======================================================
  // helpers
  function automatic logic exp_hit(input logic [3:0] t, input logic [2:0] s);
    return (t == `TWS_TYPE_MEM || t == `TWS_TYPE_PROT) && s == strap;
  endfunction : exp_hit
  task automatic check_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t bit got %b exp %b", $time, g, e);
    end
  endtask : check_bit
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t byte got %h exp %h", $time, g, e);
    end
  endtask : check_byte
  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge clk_i);
    while (cmd_ready_o !== 1'b1 && i < 9000) begin
      @(posedge clk_i);
      i++;
    end
    if (cmd_ready_o !== 1'b1) check_bit(1'b0, 1'b1);
  endtask : wait_ready
  // one host command; byte slots must take nine clocks
  task automatic op(input tws_pkg::tws_op_e o, input logic [7:0] d);
    int r0;
    wait_ready();
    r0 = rise_cnt;
    cmd_op_i <= o;
    cmd_data_i <= d;
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    wait_ready();
    if (o == tws_pkg::OP_WRITE || o == tws_pkg::OP_READ) begin
      check_byte(8'(rise_cnt - r0), 8'h09);
      check_bit(rsp_valid_o, 1'b1);
    end
  endtask : op
  task automatic addr(input logic [3:0] t, input logic [2:0] s, input logic rd);
    int v0;
    v0 = sel_cnt;
    op(tws_pkg::OP_START, 8'h00);
    op(tws_pkg::OP_WRITE, {t, s, rd});
    check_bit(rsp_nack_o, ~exp_hit(t, s));
    check_bit(1'(sel_cnt - v0), exp_hit(t, s));
    check_bit(sel_read_o, rd);
    check_byte({4'h0, sel_type_o}, {4'h0, t});
  endtask : addr
  task automatic stop_chk(input int e);
    int s0;
    s0 = stop_cnt;
    op(tws_pkg::OP_STOP, 8'h00);
    repeat (4) @(posedge clk_i);
    check_byte(8'(stop_cnt - s0), 8'(e));
  endtask : stop_chk
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // =======================================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic       rj;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    strap <= 3'($random(seed));
    @(posedge clk_i);
    check_bit(ready_o, 1'b0);
    check_bit(standby_o, 1'b1);
    check_bit(page_o, `TWS_PAGE_SEL_RESET);
    wait_ready();
    check_bit(ready_o, 1'b1);
    // address type and strap table, misses included
    addr(4'hA, strap, 1'b0);
    op(tws_pkg::OP_STOP, 8'h00);
    addr(4'h3, strap, 1'b0);
    op(tws_pkg::OP_STOP, 8'h00);
    addr(4'h6, strap ^ 3'h1, 1'b1);
    op(tws_pkg::OP_STOP, 8'h00);
    // written bytes with random refusals, corners first and last
    ops_busy_i <= 1'b1;
    addr(4'h6, strap, 1'b0);
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? 8'h00 : (k == 4) ? 8'hFF : 8'($random(seed));
      rj = 1'($random(seed));
      reject_i <= rj;
      op(tws_pkg::OP_WRITE, d);
      check_byte(rx_last, d);
      check_bit(rsp_nack_o, rj);
    end
    reject_i <= 1'b0;
    // repeated start into a read, ended by master refusal
    tx_data_i <= 8'($random(seed)) | 8'h81;
    addr(4'hA, strap, 1'b1);
    cmd_ack_i <= 1'b1;
    op(tws_pkg::OP_READ, 8'h00);
    check_byte(rsp_data_o, tx_data_i);
    cmd_ack_i <= 1'b0;
    op(tws_pkg::OP_READ, 8'h00);
    check_byte(rsp_data_o, tx_data_i);
    repeat (5) @(posedge clk_i);
    check_bit(tws_if_i.dev_sda_oe, 1'b0);
    check_byte(8'(take_cnt), 8'h02);
    cmd_ack_i <= 1'b1;
    stop_chk(0);
    check_bit(standby_o, 1'b0);
    ops_busy_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check_bit(standby_o, 1'b1);
    // recovery sequence, then a normal select
    op(tws_pkg::OP_START, 8'h00);
    op(tws_pkg::OP_WRITE, 8'hFF);
    op(tws_pkg::OP_START, 8'h00);
    op(tws_pkg::OP_STOP, 8'h00);
    check_bit(standby_o, 1'b1);
    addr(4'hA, strap, 1'b0);
    stop_chk(1);
    // stall while the slave drives a zero
    tx_data_i <= 8'h3C;
    addr(4'hA, strap, 1'b1);
    repeat (STALL + 300) @(posedge clk_i);
    check_bit(tws_if_i.sda_line, 1'b1);
    op(tws_pkg::OP_STOP, 8'h00);
    addr(4'h6, strap, 1'b0);
    stop_chk(1);
    // page select load from the user port
    page_i <= 1'b1;
    page_wr_i <= 1'b1;
    @(posedge clk_i);
    page_wr_i <= 1'b0;
    @(posedge clk_i);
    check_bit(page_o, 1'b1);
    complete_run();
  end
endmodule : two_wire_slave_interface_tb
`default_nettype wire
